// ==== include/crcu_pkg.sv ====
// crcu_pkg: register map, control layout, polynomials and bus types
// of the crc calculation unit.
// assumes a single 10 MHz bus clock; shared by design and bench.
`default_nettype none

package crcu_pkg;

  localparam int CRCU_ADDR_W = 12;
  localparam int CRCU_DATA_W = 32;

  // register offsets
  localparam logic [11:0] CRCU_OFS_CONTROL  = 12'h000;
  localparam logic [11:0] CRCU_OFS_SEED     = 12'h004;
  localparam logic [11:0] CRCU_OFS_CHECKSUM = 12'h008;
  localparam logic [11:0] CRCU_OFS_DATA     = 12'h00C;

  // values after reset
  localparam logic [7:0]  CRCU_CONTROL_RESET  = 8'h00;
  localparam logic [31:0] CRCU_CHECKSUM_RESET = 32'h00000000;

  // generator polynomials
  localparam logic [15:0] CRCU_SELECT_A_CCITT = 16'h1021;
  localparam logic [15:0] CRCU_SELECT_A_CRC16 = 16'h8005;
  localparam logic [31:0] CRCU_SELECT_A_CRC32 = 32'h04C11DB7;

  // select_a codes (1x means the 32-bit polynomial)
  localparam logic [1:0] CRCU_SEL_CCITT = 2'b00;
  localparam logic [1:0] CRCU_SEL_CRC16 = 2'b01;
  localparam int         CRCU_SEL_WIDE_BIT = 1;

  // update cycles per access size, one byte per cycle
  localparam int CRCU_CYCLES_WORD = 4;
  localparam int CRCU_CYCLES_HALF = 2;
  localparam int CRCU_CYCLES_BYTE = 1;

  localparam int CRCU_FIFO_DEPTH = 16;

  // bus encodings
  localparam logic [2:0] CRCU_HSIZE_BYTE = 3'b000;
  localparam logic [2:0] CRCU_HSIZE_HALF = 3'b001;
  localparam int         CRCU_HTRANS_ACTIVE_BIT = 1;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       result_invert;
    logic       result_byte_swap;
    logic       result_bit_flip;
    logic       data_invert;
    logic       data_byte_swap;
    logic       data_bit_flip;
    logic [1:0] select_a;
  } crcu_control_s;

  // one transformed data write waiting for the engine
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  last_idx;
  } crcu_entry_s;

  typedef enum logic [1:0] {
    CRCU_BUS_IDLE,
    CRCU_BUS_WAIT,
    CRCU_BUS_ERR
  } crcu_bus_e;

endpackage : crcu_pkg

`default_nettype wire

// ==== logic/crc_calc_unit.sv ====
// crc_calc_unit: ahb-lite slave crc unit with a write fifo feeding a
// byte-serial crc engine, plus the fifo module it uses.
// assumes ahb-lite master on clk_sys, hsel decoded outside, 12-bit
// offset on haddr.
//
// Operation
// - only polynomials 0x1021, 0x8005 and 0x04C11DB7 are computed.
// - the remainder is 16 bits for the 16-bit polynomials, 32 otherwise.
// - each data write is folded into the running crc value.
// - checksum reads return the result of the completed calculation.
// - data is processed a byte at a time, most significant byte first.
// - data writes may be word, low half-word or low byte wide.
// - an update takes 4, 2 or 1 clock cycles for word, half or byte.
// - complement, byte swap and bit flip apply to data and result.
// - data is transformed before the crc, the result after it.
// - byte writes ignore data byte swap but still get the bit flip.
// - software sets the starting crc value through the seed register.
// - select_a 00 picks 0x1021, 01 picks 0x8005, 1x picks 0x04C11DB7.
// - control bits 7 to 2 enable the result and data transforms.
`timescale 1ns/1ps
`default_nettype none

module crcu_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : crcu_fifo

module crc_calc_unit
  import crcu_pkg::*;
#(
  parameter int FIFO_DEPTH = CRCU_FIFO_DEPTH
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   hsel,
  input  wire logic [CRCU_ADDR_W-1:0] haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [CRCU_DATA_W-1:0] hwdata,
  input  wire logic                   hready,
  output var  logic [CRCU_DATA_W-1:0] hrdata,
  output var  logic                   hreadyout,
  output var  logic                   hresp
);

  // reverse the bit order inside each byte
  function automatic logic [31:0] flip_bits(input logic [31:0] v);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[(i / 8) * 8 + 7 - (i % 8)];
    end
    return r;
  endfunction : flip_bits

  // fold one byte into the crc, msb first, non-reflected
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [7:0]  b,
                                           input logic [1:0]  sel);
    logic [31:0] r;
    logic        fb;
    r  = c;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (sel[CRCU_SEL_WIDE_BIT]) begin
        fb = r[31] ^ b[7-i];
        r  = {r[30:0], 1'b0};
        if (fb) begin
          r = r ^ CRCU_SELECT_A_CRC32;
        end
      end else begin
        fb = r[15] ^ b[7-i];
        r  = {16'h0000, r[14:0], 1'b0};
        if (fb) begin
          r[15:0] = r[15:0] ^ ((sel == CRCU_SEL_CRC16) ?
                               CRCU_SELECT_A_CRC16 : CRCU_SELECT_A_CCITT);
        end
      end
    end
    return r;
  endfunction : crc_step

  crcu_bus_e              bus_state_reg;
  logic [CRCU_ADDR_W-1:0] ap_addr_reg;
  logic                   ap_write_reg;
  logic [2:0]             ap_size_reg;
  logic [CRCU_DATA_W-1:0] hrdata_reg;
  logic                   hreadyout_reg;
  logic                   hresp_reg;
  crcu_control_s          control_reg;
  logic [31:0]            crc_reg;
  logic [1:0]             idx_reg;

  logic                   accept;
  logic                   mapped;
  logic                   engine_idle;
  logic                   can_done;
  logic                   done;
  logic                   wr_control;
  logic                   wr_seed;
  logic                   wr_data;
  logic                   wide;
  crcu_entry_s            push_entry;
  crcu_entry_s            head;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  logic [31:0]            din;
  logic [31:0]            dflip;
  logic [31:0]            dswap;
  logic [31:0]            dmask;
  logic [31:0]            rflip;
  logic [31:0]            rswap;
  logic [31:0]            checksum_out;
  logic [1:0]             pos;
  logic [7:0]             cur_byte;

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;

  assign wide   = control_reg.select_a[CRCU_SEL_WIDE_BIT];
  assign accept = hsel && hready && htrans[CRCU_HTRANS_ACTIVE_BIT];
  assign mapped = (ap_addr_reg == CRCU_OFS_CONTROL) ||
                  (ap_addr_reg == CRCU_OFS_SEED) ||
                  (ap_addr_reg == CRCU_OFS_CHECKSUM) ||
                  (ap_addr_reg == CRCU_OFS_DATA);
  assign engine_idle = !fifo_out_valid;

  // data writes wait only for fifo room; everything else waits until the
  // engine has drained, so reads and seed writes see a settled crc
  always_comb begin
    if (ap_write_reg && (ap_addr_reg == CRCU_OFS_DATA)) begin
      can_done = fifo_in_ready;
    end else begin
      can_done = engine_idle;
    end
  end

  assign done = (bus_state_reg == CRCU_BUS_WAIT) && mapped && can_done;
  assign wr_control = done && ap_write_reg &&
                      (ap_addr_reg == CRCU_OFS_CONTROL);
  assign wr_seed = done && ap_write_reg && (ap_addr_reg == CRCU_OFS_SEED);
  assign wr_data = done && ap_write_reg && (ap_addr_reg == CRCU_OFS_DATA);

  // input side: right-aligned data, bit flip, byte swap, complement
  always_comb begin
    unique case (ap_size_reg)
      CRCU_HSIZE_BYTE: begin
        din        = {24'h000000, hwdata[7:0]};
        dmask      = 32'h000000FF;
        push_entry.last_idx = 2'(CRCU_CYCLES_BYTE - 1);
      end
      CRCU_HSIZE_HALF: begin
        din        = {16'h0000, hwdata[15:0]};
        dmask      = 32'h0000FFFF;
        push_entry.last_idx = 2'(CRCU_CYCLES_HALF - 1);
      end
      default: begin
        din        = hwdata;
        dmask      = 32'hFFFFFFFF;
        push_entry.last_idx = 2'(CRCU_CYCLES_WORD - 1);
      end
    endcase
    dflip = control_reg.data_bit_flip ? flip_bits(din) : din;
    dswap = dflip;
    if (control_reg.data_byte_swap) begin
      if (ap_size_reg == CRCU_HSIZE_HALF) begin
        dswap = {16'h0000, dflip[7:0], dflip[15:8]};
      end else if (ap_size_reg != CRCU_HSIZE_BYTE) begin
        dswap = {dflip[7:0], dflip[15:8], dflip[23:16], dflip[31:24]};
      end
    end
    push_entry.data = control_reg.data_invert ?
                      (dswap ^ dmask) : dswap;
  end

  crcu_fifo #(
    .WIDTH ($bits(crcu_entry_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (wr_data),
    .in_ready  (fifo_in_ready),
    .in_data   (push_entry),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (head)
  );

  // engine: one byte per cycle, high byte first; the entry leaves the
  // fifo on its last byte so a word holds the head for exactly 4 cycles
  assign pos            = head.last_idx - idx_reg;
  assign cur_byte       = head.data[{pos, 3'b000} +: 8];
  assign fifo_out_ready = fifo_out_valid &&
                          (idx_reg == head.last_idx);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      idx_reg <= '0;
    end else if (fifo_out_ready) begin
      idx_reg <= '0;
    end else if (fifo_out_valid) begin
      idx_reg <= idx_reg + 1'b1;
    end
  end

  // seed writes only complete while the engine is idle, so they never
  // collide with an update
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      crc_reg <= CRCU_CHECKSUM_RESET;
    end else if (wr_seed) begin
      crc_reg <= wide ? hwdata : {16'h0000, hwdata[15:0]};
    end else if (fifo_out_valid) begin
      crc_reg <= crc_step(crc_reg, cur_byte,
                          control_reg.select_a);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      control_reg <= CRCU_CONTROL_RESET;
    end else if (wr_control) begin
      control_reg <= hwdata[$bits(crcu_control_s)-1:0];
    end
  end

  // result side: bit flip, byte swap, complement within the crc width
  always_comb begin
    rflip = control_reg.result_bit_flip ? flip_bits(crc_reg) : crc_reg;
    rswap = rflip;
    if (control_reg.result_byte_swap) begin
      if (wide) begin
        rswap = {rflip[7:0], rflip[15:8], rflip[23:16], rflip[31:24]};
      end else begin
        rswap = {16'h0000, rflip[7:0], rflip[15:8]};
      end
    end
    if (control_reg.result_invert) begin
      rswap = rswap ^ 32'hFFFFFFFF;
    end
    checksum_out = wide ? rswap : {16'h0000, rswap[15:0]};
  end

  // bus: every access gets at least one wait state; unmapped offsets
  // get the two-cycle error answer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bus_state_reg <= CRCU_BUS_IDLE;
      ap_addr_reg   <= '0;
      ap_write_reg  <= 1'b0;
      ap_size_reg   <= '0;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      hrdata_reg    <= '0;
    end else begin
      unique case (bus_state_reg)
        CRCU_BUS_IDLE: begin
          hresp_reg  <= 1'b0;
          hrdata_reg <= '0;
          if (accept) begin
            ap_addr_reg   <= haddr;
            ap_write_reg  <= hwrite;
            ap_size_reg   <= hsize;
            hreadyout_reg <= 1'b0;
            bus_state_reg <= CRCU_BUS_WAIT;
          end
        end
        CRCU_BUS_WAIT: begin
          if (!mapped) begin
            hresp_reg     <= 1'b1;
            bus_state_reg <= CRCU_BUS_ERR;
          end else if (can_done) begin
            hreadyout_reg <= 1'b1;
            bus_state_reg <= CRCU_BUS_IDLE;
            if (!ap_write_reg && (ap_addr_reg == CRCU_OFS_CHECKSUM)) begin
              hrdata_reg <= checksum_out;
            end else if (!ap_write_reg &&
                         (ap_addr_reg == CRCU_OFS_CONTROL)) begin
              hrdata_reg <= {24'h000000, control_reg};
            end
          end
        end
        CRCU_BUS_ERR: begin
          hreadyout_reg <= 1'b1;
          bus_state_reg <= CRCU_BUS_IDLE;
        end
      endcase
    end
  end

endmodule : crc_calc_unit

`default_nettype wire

// ==== test/crcu_monitor.sv ====
// crcu_monitor: bus-level assertions on the crc unit ports.
// assumes an ahb-lite master with hready looped from hreadyout.
`timescale 1ns/1ps
`default_nettype none

module crcu_monitor
  import crcu_pkg::*;
#(
  parameter int FIFO_DEPTH = CRCU_FIFO_DEPTH
) (
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire logic                   hsel,
  input wire logic [CRCU_ADDR_W-1:0] haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [2:0]             hsize,
  input wire logic [CRCU_DATA_W-1:0] hwdata,
  input wire logic                   hready,
  input wire logic [CRCU_DATA_W-1:0] hrdata,
  input wire logic                   hreadyout,
  input wire logic                   hresp
);
  logic       take;
  logic       mapped;
  logic       seed_rd_q;
  logic [7:0] stall_q;
  assign take   = hsel && hready && htrans[CRCU_HTRANS_ACTIVE_BIT];
  assign mapped = haddr[11:4] == 8'h00 && haddr[1:0] == 2'b00;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // seed reads are flagged until they complete
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) seed_rd_q <= 1'b0;
    else if (take && !hwrite && haddr == CRCU_OFS_SEED) seed_rd_q <= 1'b1;
    else if (hreadyout) seed_rd_q <= 1'b0;
  end
  // 8 bits cover the deepest stall of a 16-entry fifo
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) stall_q <= 8'h00;
    else if (hreadyout) stall_q <= 8'h00;
    else stall_q <= stall_q + 8'h01;
  end
  sequence s_word_wr;
    take && hwrite && haddr == CRCU_OFS_DATA && hsize > CRCU_HSIZE_HALF;
  endsequence
  // a read taken four cycles after a word write still sees the engine busy
  sequence s_wr_rd;
    s_word_wr ##4 (take && !hwrite);
  endsequence
  // hresp only rises one cycle after the wait state has started
  sequence s_err;
    (!hreadyout && !hresp) ##1 (!hreadyout && hresp) ##1
    (hreadyout && hresp) ##1 !hresp;
  endsequence
  AST_WORD_FOUR: assert property (s_wr_rd |=> !hreadyout [*2])
    else $error("word update shorter than four cycles");
  AST_UNMAPPED: assert property (take && !mapped |=> s_err)
    else $error("unmapped access without two-cycle error");
  AST_MAPPED_OKAY: assert property (take && mapped |=> !hresp [*2])
    else $error("mapped access answered with error");
  AST_WAIT: assert property (take |=> !hreadyout)
    else $error("transfer without wait state");
  AST_RD_ZERO: assert property (hreadyout && $past(hreadyout) |-> hrdata == '0)
    else $error("read data held past completion");
  AST_IDLE_READY: assert property (hreadyout && !hresp && !take |=> hreadyout)
    else $error("wait state with no transfer");
  AST_SEED_READ: assert property (seed_rd_q && hreadyout |-> hrdata == '0)
    else $error("seed register read back nonzero");
  AST_WAIT_BOUND: assert property (int'(stall_q) <= 4 * FIFO_DEPTH + 2)
    else $error("wait state too long");
endmodule : crcu_monitor

bind crc_calc_unit crcu_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
  .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

`default_nettype wire

// ==== test/crcu_ahb_master.sv ====
// crcu_ahb_master: ahb-lite master model, single transfers only.
// assumes it alone drives the bus; hready is looped from hreadyout.
`timescale 1ns/1ps
`default_nettype none

module crcu_ahb_master
  import crcu_pkg::*;
(
  input  wire logic                   clk_sys,
  output var  logic                   hsel,
  output var  logic [CRCU_ADDR_W-1:0] haddr,
  output var  logic [1:0]             htrans,
  output var  logic                   hwrite,
  output var  logic [2:0]             hsize,
  output var  logic [CRCU_DATA_W-1:0] hwdata,
  input  wire logic [CRCU_DATA_W-1:0] hrdata,
  input  wire logic                   hreadyout,
  input  wire logic                   hresp
);
  initial begin
    hsel   = 1'b0;
    haddr  = 12'hFFC;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'hA5A5A5A5;
  end
  // released lines show inverted values so stale data is never reused
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [2:0] sz, input logic [31:0] d,
                      output logic [31:0] rd, output logic rsp);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= sz;
    @(posedge clk_sys);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    haddr  <= ~a;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd     = hrdata;
    rsp    = hresp;
    hwdata <= ~d;
  endtask : xfer
  // back-to-back word writes: each address phase rides on the data phase
  // of the one before, so the fifo fills faster than the engine drains it
  task automatic burst(input logic [11:0] a, input logic [31:0] d0,
                       input logic [31:0] step, input int n);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= 1'b1;
    hsize  <= 3'b010;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hwdata <= d0 + step * i;
      if (i == n - 1) begin
        hsel   <= 1'b0;
        htrans <= 2'b00;
        haddr  <= ~a;
      end
    end
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hwdata <= ~hwdata;
  endtask : burst
endmodule : crcu_ahb_master

`default_nettype wire

// ==== test/crc_calc_unit_tb.sv ====
// crc_calc_unit_tb: self-checking bench for the crc unit.
// assumes the master model and the bound checker compile first.
`timescale 1ns/1ps
`default_nettype none

module crc_calc_unit_tb
  import crcu_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  logic        hsel, hwrite, hreadyout, hresp, rsp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, crc;
  logic [7:0]  ctl_v;
  int          fails = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #50 clk_sys = ~clk_sys;
  crc_calc_unit #(.FIFO_DEPTH(16)) u_dut (.clk_sys(clk_sys),
    .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  crcu_ahb_master u_mst (.clk_sys(clk_sys), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      final_report();
    end
  end
  function automatic logic [31:0] msk(input int n);
    return (n == 4) ? 32'hFFFFFFFF : (n == 2) ? 32'h0000FFFF : 32'h000000FF;
  endfunction : msk
  function automatic logic [31:0] flip8(input logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = v[i - i % 8 + 7 - i % 8];
    return r;
  endfunction : flip8
  function automatic logic [31:0] swapn(input logic [31:0] v, input int n);
    if (n == 4) return {v[7:0], v[15:8], v[23:16], v[31:24]};
    return (n == 2) ? {16'h0000, v[7:0], v[15:8]} : v;
  endfunction : swapn
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input int n);
    u_mst.xfer(1'b1, a, n == 1 ? CRCU_HSIZE_BYTE : n == 2 ? CRCU_HSIZE_HALF
               : 3'b010, d, rd, rsp);
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    u_mst.xfer(1'b0, a, 3'b010, 32'h00000000, rd, rsp);
  endtask : rdr
  task automatic set_ctl(input logic [7:0] c);
    ctl_v = c;
    wr(CRCU_OFS_CONTROL, {24'h000000, c}, 4);
  endtask : set_ctl
  task automatic seed(input logic [31:0] s);
    crc = ctl_v[1] ? s : s & 32'h0000FFFF;
    wr(CRCU_OFS_SEED, crc, 4);
  endtask : seed
  task automatic fold(input logic [31:0] d, input int n);
    logic [31:0] x;
    logic [31:0] p;
    int          w;
    x = ctl_v[2] ? flip8(d) : d;
    if (ctl_v[3] && n > 1) x = swapn(x, n);
    x = (ctl_v[4] ? ~x : x) & msk(n);
    w = ctl_v[1] ? 32 : 16;
    p = ctl_v[1] ? CRCU_SELECT_A_CRC32
        : {16'h0000, ctl_v[0] ? CRCU_SELECT_A_CRC16 : CRCU_SELECT_A_CCITT};
    for (int k = n - 1; k >= 0; k--) begin
      crc = crc ^ ({24'h000000, x[8*k +: 8]} << (w - 8));
      for (int j = 0; j < 8; j++) crc = ((crc << 1) ^ (crc[w-1] ? p : 0))
                                        & msk(w / 8);
    end
  endtask : fold
  task automatic dat(input logic [31:0] d, input int n);
    fold(d, n);
    wr(CRCU_OFS_DATA, d & msk(n), n);
  endtask : dat
  task automatic chk_sum();
    logic [31:0] e;
    e = ctl_v[5] ? flip8(crc) : crc;
    if (ctl_v[6]) e = swapn(e, ctl_v[1] ? 4 : 2);
    e = (ctl_v[7] ? ~e : e) & msk(ctl_v[1] ? 4 : 2);
    rdr(CRCU_OFS_CHECKSUM);
    check(rd, e);
  endtask : chk_sum
  task automatic t_reset();
    rdr(CRCU_OFS_CONTROL);
    check(rd, 32'h00000000);
    ctl_v = 8'h00;
    crc = 32'h00000000;
    chk_sum();
  endtask : t_reset
  task automatic t_select_a();
    for (int s = 0; s < 4; s++) begin
      set_ctl(8'(s));
      rdr(CRCU_OFS_CONTROL);
      check(rd, 32'(s));
      seed(32'h1D0F5A3C);
      dat(32'h31323334, 4);
      dat(32'hC0FFEE11, 4);
      chk_sum();
      seed(32'hFFFFFFFF);
      dat(32'h000000A7, 1);
      chk_sum();
    end
  endtask : t_select_a
  task automatic t_xform();
    logic [7:0] tbl [8];
    tbl = '{8'h1C, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'hE0};
    for (int i = 0; i < 8; i++) begin
      for (int s = 0; s < 3; s++) begin
        set_ctl(tbl[i] | 8'(s));
        seed(32'h89ABCDEF);
        dat(32'h0000B1C2, 2);
        dat(32'h00000093, 1);
        dat(32'h12345678, 4);
        chk_sum();
      end
    end
  endtask : t_xform
  task automatic t_err();
    rdr(12'h010);
    check({31'h0, rsp}, 32'h00000001);
    rdr(CRCU_OFS_SEED);
    check(rd, 32'h00000000);
    wr(CRCU_OFS_CHECKSUM, 32'hDEADBEEF, 4);
    chk_sum();
  endtask : t_err
  task automatic t_fill();
    set_ctl(8'h02);
    seed(32'hFFFFFFFF);
    for (int i = 0; i < 80; i++) fold(32'h01030507 * i, 4);
    u_mst.burst(CRCU_OFS_DATA, 32'h00000000, 32'h01030507, 80);
    chk_sum();
  endtask : t_fill
  task automatic final_report();
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_select_a();
    t_xform();
    t_err();
    t_fill();
    final_report();
  end
endmodule : crc_calc_unit_tb

`default_nettype wire
